// *** logic/dcc_pkg.sv ***
`default_nettype none
package dcc_pkg;

  localparam int NCMP = 2;

  // Register byte offsets, one aligned 32-bit word each
  localparam logic [1:0][7:0] OFF_CTRL_A = {8'h08, 8'h00};
  localparam logic [1:0][7:0] OFF_CTRL_B = {8'h0C, 8'h04};
  localparam logic [7:0] OFF_MIRROR = 8'h10;
  localparam logic [7:0] OFF_FLAGS = 8'h14;

  // Control A field positions
  localparam int A_EN = 7;
  localparam int A_RES = 6;
  localparam int A_OE = 5;
  localparam int A_POL = 4;
  localparam int A_SP = 2;
  localparam int A_HYS = 1;
  localparam int A_SYNC = 0;

  // Control B field positions
  localparam int B_RISE = 7;
  localparam int B_FALL = 6;
  localparam int B_PSEL = 4;
  localparam int B_NSEL = 0;

  localparam logic SP_RST = 1'b1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DCC_PSRC_PIN = 2'h0,
    DCC_PSRC_DAC = 2'h1,
    DCC_PSRC_FIXED = 2'h2,
    DCC_PSRC_GND = 2'h3
  } dcc_psrc_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } dcc_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dcc_axil_rsp_t;

  // Settings driven into one analog comparator
  typedef struct packed {
    logic enable;
    logic connect;
    logic speed;
    logic hyst;
    dcc_psrc_t psel;
    logic [1:0] nsel;
  } dcc_analog_t;

  typedef struct packed {
    logic [NCMP-1:0] en;
    logic [NCMP-1:0] oe;
    logic [NCMP-1:0] pol;
    logic [NCMP-1:0] sp;
    logic [NCMP-1:0] hys;
    logic [NCMP-1:0] sync;
    logic [NCMP-1:0] rise_en;
    logic [NCMP-1:0] fall_en;
    logic [NCMP-1:0][1:0] psel;
    logic [NCMP-1:0][1:0] nsel;
    logic [NCMP-1:0] res;
    logic [NCMP-1:0] prev;
    logic [NCMP-1:0] sync_res;
    logic [NCMP-1:0] flag;
    logic tclk_prev;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dcc_state_t;

  localparam dcc_state_t STATE_RST = '{sp: {NCMP{SP_RST}}, default: '0};

endpackage
`default_nettype wire

// *** logic/dcc_top.sv ***
// Summary of operation
// (RULE_01) Comparator runs only while enabled
// (RULE_02) Result high when positive exceeds negative
// (RULE_03) Result readable in control and mirror
// (RULE_04) Pin driven when output enabled, direction output, enabled
// (RULE_05) Output enable overrides port latch regardless
// (RULE_06) Internal result registered each cycle
// (RULE_07) Invert bit inverts the result
// (RULE_08) Speed select resets to normal speed
// (RULE_09) Hysteresis bit enables hysteresis
// (RULE_10) Sync mode latches on timer falling edge
// (RULE_11) Prescaler output supplies the latching edge
// (RULE_12) Result offered as timer gate source
// (RULE_13) Enabled rising/falling edges set the flag
// (RULE_14) Software clears flag; new edge wins
// (RULE_15) Invert or enable toggles can raise edges
// (RULE_16) Software sets all enables to use interrupt
// (RULE_17) Four sources for the non-inverting input
// (RULE_18) Disabled comparator disconnects all inputs
// (RULE_19) Four pins for the inverting input
// (RULE_20) Both results feed PWM shutdown logic
// (RULE_21) Software verifies result after initialization
// (RULE_22) Positive select: pin, DAC, reference, ground
// (RULE_23) Mirror: bit1 second, bit0 first, rest zero
// (RULE_24) Without sync, result passes asynchronously
// (RULE_25) Edges detected on registered post-inversion result
`timescale 1ns/1ns
`default_nettype none
module dcc_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register bus
  input wire dcc_pkg::dcc_axil_req_t axi_req,
  output var dcc_pkg::dcc_axil_rsp_t axi_rsp,
  // Analog front end
  input wire logic [1:0] raw_compare,
  output var dcc_pkg::dcc_analog_t [1:0] analog_ctrl,
  // Companion timer
  input wire logic timer_src_clk,
  input wire logic timer_prescale_clk,
  input wire logic timer_prescale_used,
  output logic [1:0] timer_gate,
  // Pins
  input wire logic [1:0] pin_direction,
  output logic [1:0] pin_out,
  output logic [1:0] pin_out_en,
  output logic [1:0] pin_override,
  // Shutdown sources and flags
  output logic [1:0] pwm_shutdown_src,
  output logic [1:0] compare_irq_flag
);

  dcc_pkg::dcc_state_t s_q;
  dcc_pkg::dcc_state_t s_d;

  logic [1:0] pol_res;
  logic [1:0] out_sel;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [1:0] edge_hit;
  logic [1:0] flag_clr;
  logic tclk_sel;
  logic tfall;
  logic wr_go;
  logic wr_ok;
  logic lane0;
  logic [32:0] rd_word;

  function automatic logic [7:0] ctrl_a_val(input dcc_pkg::dcc_state_t s, input int i);
    logic [7:0] v;
    v = 8'h00;
    v[dcc_pkg::A_EN] = s.en[i];
    v[dcc_pkg::A_RES] = s.res[i]; // RULE_03
    v[dcc_pkg::A_OE] = s.oe[i];
    v[dcc_pkg::A_POL] = s.pol[i];
    v[dcc_pkg::A_SP] = s.sp[i];
    v[dcc_pkg::A_HYS] = s.hys[i];
    v[dcc_pkg::A_SYNC] = s.sync[i];
    return v;
  endfunction

  function automatic logic [7:0] ctrl_b_val(input dcc_pkg::dcc_state_t s, input int i);
    logic [7:0] v;
    v = 8'h00;
    v[dcc_pkg::B_RISE] = s.rise_en[i];
    v[dcc_pkg::B_FALL] = s.fall_en[i];
    v[dcc_pkg::B_PSEL +: 2] = s.psel[i];
    v[dcc_pkg::B_NSEL +: 2] = s.nsel[i];
    return v;
  endfunction

  function automatic logic [32:0] read_reg(input dcc_pkg::dcc_state_t s, input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    for (int i = 0; i < dcc_pkg::NCMP; i++) begin
      if (a == dcc_pkg::OFF_CTRL_A[i]) begin
        r = {1'b0, 24'h00_0000, ctrl_a_val(s, i)};
      end
      if (a == dcc_pkg::OFF_CTRL_B[i]) begin
        r = {1'b0, 24'h00_0000, ctrl_b_val(s, i)};
      end
    end
    if (a == dcc_pkg::OFF_MIRROR) begin
      r = {1'b0, 30'h0000_0000, s.res}; // RULE_23 RULE_03
    end
    if (a == dcc_pkg::OFF_FLAGS) begin
      r = {1'b0, 30'h0000_0000, s.flag};
    end
    return r;
  endfunction

  localparam dcc_pkg::dcc_state_t STATE_ZERO = '{default: '0};

  function automatic logic addr_mapped(input logic [7:0] a);
    logic [32:0] t;
    t = read_reg(STATE_ZERO, a);
    return !t[32];
  endfunction

  // Disabled comparator presents a low raw level; inversion still applies
  assign pol_res = (s_q.en & raw_compare) ^ s_q.pol; // RULE_01 RULE_02 RULE_07 RULE_15

  assign tclk_sel = timer_prescale_used ? timer_prescale_clk : timer_src_clk; // RULE_11
  assign tfall = s_q.tclk_prev & ~tclk_sel; // RULE_10

  // Synchronous mode output comes from the timer-edge latch, else straight through
  assign out_sel = (s_q.sync & s_q.sync_res) | (~s_q.sync & pol_res); // RULE_10 RULE_24

  assign rise = s_q.res & ~s_q.prev; // RULE_25
  assign fall = ~s_q.res & s_q.prev; // RULE_25
  assign edge_hit = (rise & s_q.rise_en) | (fall & s_q.fall_en); // RULE_13

  assign wr_go = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
  assign wr_ok = addr_mapped(s_q.awaddr);
  assign lane0 = s_q.wstrb[0];
  assign rd_word = read_reg(s_q, axi_req.araddr);
  assign flag_clr = (wr_go && s_q.awaddr == dcc_pkg::OFF_FLAGS && lane0) ?
    s_q.wdata[1:0] : 2'b00; // RULE_14

  always_comb begin
    s_d = s_q;
    s_d.tclk_prev = tclk_sel;
    s_d.res = pol_res; // RULE_06
    s_d.prev = s_q.res; // RULE_25
    if (tfall) begin
      s_d.sync_res = pol_res; // RULE_10
    end
    // Hardware set wins over a clearing write in the same cycle
    s_d.flag = (s_q.flag & ~flag_clr) | edge_hit; // RULE_13 RULE_14

    if (axi_req.awvalid && !s_q.aw_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_q.w_got && !s_q.bvalid) begin
      s_d.w_got = 1'b1;
      s_d.wdata = axi_req.wdata;
      s_d.wstrb = axi_req.wstrb;
    end
    if (wr_go) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_ok ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
      for (int i = 0; i < dcc_pkg::NCMP; i++) begin
        if (lane0 && s_q.awaddr == dcc_pkg::OFF_CTRL_A[i]) begin
          s_d.en[i] = s_q.wdata[dcc_pkg::A_EN]; // RULE_01
          s_d.oe[i] = s_q.wdata[dcc_pkg::A_OE];
          s_d.pol[i] = s_q.wdata[dcc_pkg::A_POL]; // RULE_07
          s_d.sp[i] = s_q.wdata[dcc_pkg::A_SP]; // RULE_08
          s_d.hys[i] = s_q.wdata[dcc_pkg::A_HYS]; // RULE_09
          s_d.sync[i] = s_q.wdata[dcc_pkg::A_SYNC];
        end
        if (lane0 && s_q.awaddr == dcc_pkg::OFF_CTRL_B[i]) begin
          s_d.rise_en[i] = s_q.wdata[dcc_pkg::B_RISE];
          s_d.fall_en[i] = s_q.wdata[dcc_pkg::B_FALL];
          s_d.psel[i] = s_q.wdata[dcc_pkg::B_PSEL +: 2]; // RULE_17
          s_d.nsel[i] = s_q.wdata[dcc_pkg::B_NSEL +: 2]; // RULE_19
        end
      end
    end
    if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end

    if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_word[31:0];
      s_d.rresp = rd_word[32] ? dcc_pkg::RESP_SLVERR :
        dcc_pkg::RESP_OKAY;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= dcc_pkg::STATE_RST; // RULE_08
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    axi_rsp.awready = ~s_q.aw_got & ~s_q.bvalid;
    axi_rsp.wready = ~s_q.w_got & ~s_q.bvalid;
    axi_rsp.bvalid = s_q.bvalid;
    axi_rsp.bresp = s_q.bresp;
    axi_rsp.arready = ~s_q.rvalid;
    axi_rsp.rvalid = s_q.rvalid;
    axi_rsp.rdata = s_q.rdata;
    axi_rsp.rresp = s_q.rresp;
    for (int i = 0; i < dcc_pkg::NCMP; i++) begin
      analog_ctrl[i].enable = s_q.en[i]; // RULE_01
      analog_ctrl[i].connect = s_q.en[i]; // RULE_18
      analog_ctrl[i].speed = s_q.sp[i]; // RULE_08
      analog_ctrl[i].hyst = s_q.hys[i]; // RULE_09
      analog_ctrl[i].psel = dcc_pkg::dcc_psrc_t'(s_q.psel[i]); // RULE_22
      analog_ctrl[i].nsel = s_q.nsel[i]; // RULE_19
    end
  end

  assign pin_override = s_q.oe; // RULE_05
  assign pin_out_en = s_q.oe & ~pin_direction & s_q.en; // RULE_04
  assign pin_out = out_sel;
  assign timer_gate = out_sel; // RULE_12
  assign pwm_shutdown_src = out_sel; // RULE_20
  assign compare_irq_flag = s_q.flag;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_flag_set_wins: assert property (edge_hit[0] |=> compare_irq_flag[0]) // RULE_14
    else $error("edge did not leave flag 0 set");
  a_flag_clear_cause: assert property ($fell(compare_irq_flag[1]) |-> $past(flag_clr[1])) // RULE_14
    else $error("flag 1 fell without a clearing write");
  a_rise_to_flag: assert property ((s_q.res[1] && !s_q.prev[1] && s_q.rise_en[1])
    |=> compare_irq_flag[1]) // RULE_13
    else $error("enabled rising edge missed");
  a_edge_from_result: assert property (($rose(s_q.res[0]) && s_q.rise_en[0]) // RULE_25
    |=> compare_irq_flag[0])
    else $error("registered rise not detected");
  a_off_result_low: assert property ((!s_q.en[0] && !s_q.pol[0]) |=> !s_q.res[0]) // RULE_01
    else $error("disabled comparator produced high");
  a_invert_result: assert property ((s_q.en[0] && raw_compare[0] && s_q.pol[0])
    |=> !s_q.res[0]) // RULE_07
    else $error("inverted result wrong");
  a_pin_needs_en: assert property (!s_q.en[1] |-> !pin_out_en[1]) // RULE_04
    else $error("pin driven while disabled");
  a_sync_hold: assert property ((s_q.sync[0] && !tfall) |=> $stable(timer_gate[0])
    or $past(!s_q.sync[0]) or !s_q.sync[0]) // RULE_10
    else $error("sync output moved without timer edge");
  a_sync_latch: assert property (tfall |=> s_q.sync_res == $past(pol_res)) // RULE_11
    else $error("timer falling edge did not latch");
  a_disconnect: assert property (!s_q.en[0] |-> !analog_ctrl[0].connect) // RULE_18
    else $error("inputs connected while disabled");
  a_write_resp: assert property ((s_q.aw_got && s_q.w_got && !s_q.bvalid)
    |=> axi_rsp.bvalid) // RULE_03
    else $error("write response late");

  // Result path
  a_res_sample: assert property (1'b1 // RULE_06
    |=> s_q.res == $past(pol_res))
    else $error("result not registered each cycle");
  a_pass_result: assert property ((s_q.en[1] && !s_q.pol[1]) // RULE_02
    |=> s_q.res[1] == $past(raw_compare[1]))
    else $error("plain result does not follow input");
  a_invert_one: assert property ((s_q.en[1] && s_q.pol[1]) // RULE_07
    |=> s_q.res[1] == !$past(raw_compare[1]))
    else $error("inverted result 1 wrong");
  a_off_result_inv: assert property ((!s_q.en[1] && s_q.pol[1]) // RULE_15
    |=> s_q.res[1])
    else $error("disabled inverted comparator not high");
  a_mirror_read: assert property (axi_rsp.arready && axi_req.arvalid // RULE_23
    && axi_req.araddr == dcc_pkg::OFF_MIRROR |=> axi_rsp.rdata == {30'h0, $past(s_q.res)})
    else $error("mirror read wrong");
  a_ctrl_res_read: assert property (axi_rsp.arready && axi_req.arvalid // RULE_03
    && axi_req.araddr == dcc_pkg::OFF_CTRL_A[1] |=> axi_rsp.rdata[6] == $past(s_q.res[1]))
    else $error("control result bit wrong");
  a_flags_read: assert property (axi_rsp.arready && axi_req.arvalid // RULE_13
    && axi_req.araddr == dcc_pkg::OFF_FLAGS |=> axi_rsp.rdata == {30'h0, $past(s_q.flag)})
    else $error("flag read wrong");

  // Pin and outputs
  a_override_no_en: assert property ((s_q.oe[0] && !s_q.en[0]) // RULE_05
    |-> pin_override[0])
    else $error("override depends on enable");
  a_pin_dir_in: assert property (pin_direction[0] // RULE_04
    |-> !pin_out_en[0])
    else $error("input pin driven");
  a_pin_all_set: assert property ((s_q.oe[1] && !pin_direction[1] && s_q.en[1]) // RULE_04
    |-> pin_out_en[1])
    else $error("pin not driven");
  a_no_oe_pin: assert property (!s_q.oe[0] // RULE_05
    |-> !pin_out_en[0] && !pin_override[0])
    else $error("pin used without output enable");
  a_async_gate: assert property (!s_q.sync[1] // RULE_24
    |-> timer_gate[1] == pol_res[1])
    else $error("async gate not direct");
  a_async_pin: assert property (!s_q.sync[0] // RULE_24
    |-> pin_out[0] == pol_res[0])
    else $error("async pin not direct");
  a_sync_pin: assert property (s_q.sync[1] // RULE_10
    |-> pin_out[1] == s_q.sync_res[1])
    else $error("sync pin not from latch");
  a_pwm_both: assert property (1'b1 // RULE_20
    |-> pwm_shutdown_src == pin_out)
    else $error("shutdown source differs");
  a_gate_same: assert property (1'b1 // RULE_12
    |-> timer_gate == pwm_shutdown_src)
    else $error("gate source differs");

  // Timer edge select
  a_prescale_edge: assert property ((timer_prescale_used && s_q.tclk_prev) // RULE_11
    && !timer_prescale_clk |-> tfall)
    else $error("prescaled fall missed");
  a_src_edge: assert property ((!timer_prescale_used && s_q.tclk_prev) // RULE_10
    && !timer_src_clk |-> tfall)
    else $error("source fall missed");
  a_no_rise_latch: assert property ((!s_q.tclk_prev || tclk_sel) // RULE_10
    |=> s_q.sync_res == $past(s_q.sync_res))
    else $error("latch moved without fall");
  a_sync_gate_b: assert property ((tfall && s_q.sync[1]) // RULE_10
    |=> !s_q.sync[1] || timer_gate[1] == $past(pol_res[1]))
    else $error("sync gate 1 not latched");

  // Edge detection and flags
  a_fall_to_flag: assert property ((!s_q.res[0] && s_q.prev[0] && s_q.fall_en[0]) // RULE_13
    |=> compare_irq_flag[0])
    else $error("enabled falling edge missed");
  a_quiet_no_set: assert property ((!edge_hit[1] && !compare_irq_flag[1]) // RULE_13
    |=> !compare_irq_flag[1])
    else $error("flag set without edge");
  a_flag_hold: assert property ((compare_irq_flag[0] && !flag_clr[0]) // RULE_14
    |=> compare_irq_flag[0])
    else $error("flag lost without clear");
  a_clear_works: assert property ((flag_clr[1] && !edge_hit[1]) // RULE_14
    |=> !compare_irq_flag[1])
    else $error("clear did not take");
  a_prev_tracks: assert property (1'b1 // RULE_25
    |=> s_q.prev == $past(s_q.res))
    else $error("previous sample wrong");

  // Analog settings
  a_disconnect_b: assert property (!s_q.en[1] // RULE_18
    |-> !analog_ctrl[1].connect && !analog_ctrl[1].enable)
    else $error("comparator 1 active while disabled");
  a_speed_hyst: assert property (1'b1 // RULE_08
    |-> analog_ctrl[0].speed == s_q.sp[0] && analog_ctrl[0].hyst == s_q.hys[0])
    else $error("speed or hysteresis not applied");

  // Register bus
  a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready
    |=> axi_rsp.rvalid)
    else $error("read answer late");
  a_read_holds: assert property (axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
  a_write_holds: assert property (axi_rsp.bvalid && !axi_req.bready
    |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
  a_busy_refuse: assert property (s_q.bvalid
    |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write taken while response pending");
  a_bad_read: assert property (axi_req.arvalid && axi_rsp.arready
    && !addr_mapped(axi_req.araddr) |=> axi_rsp.rresp == dcc_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");

  c_edge_flag: cover property (edge_hit[0] ##1 compare_irq_flag[0]);
  c_sync_latch: cover property (s_q.sync[1] && tfall);
  c_read_done: cover property (axi_rsp.rvalid && axi_req.rready);
  c_fall_flag: cover property (s_q.fall_en[0] && fall[0]);
  c_override_only: cover property (pin_override[0] && !pin_out_en[0]);

endmodule // dcc_top
`default_nettype wire

// *** tb/dcc_far_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module dcc_far_model (
  // Clock
  input wire logic ref_clk,
  // Comparator settings and input levels
  input wire dcc_pkg::dcc_analog_t [1:0] analog_ctrl,
  input wire logic [3:0][7:0] pos_lvl,
  input wire logic [3:0][7:0] neg_lvl,
  // Comparator and timer outputs
  output logic [1:0] raw_compare,
  output logic timer_src_clk,
  output logic timer_prescale_clk
);
  logic [5:0] cnt_q = '0;
  logic [7:0] vp;
  always_ff @(posedge ref_clk) cnt_q <= cnt_q + 6'h01;
  assign timer_src_clk = cnt_q[3];
  assign timer_prescale_clk = cnt_q[5];
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      vp = (analog_ctrl[i].psel == dcc_pkg::DCC_PSRC_GND) ? 8'h00 : pos_lvl[analog_ctrl[i].psel];
      // Disconnected inputs give a level that changes every cycle
      raw_compare[i] = analog_ctrl[i].connect ? (vp > neg_lvl[analog_ctrl[i].nsel]) : cnt_q[0];
    end
  end
endmodule // dcc_far_model
`default_nettype wire

// *** tb/dual_comparator_control_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module dual_comparator_control_tb_top;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  dcc_pkg::dcc_axil_req_t req = '0;
  dcc_pkg::dcc_axil_rsp_t rsp;
  dcc_pkg::dcc_analog_t [1:0] actl;
  logic [1:0] raw, gate, pout, poe, povr, pwm, flg;
  logic [1:0] dir = 2'h0;
  logic tsrc, tpre, tclk;
  logic tpu = 1'b0;
  logic [3:0][7:0] pos = '0;
  logic [3:0][7:0] neg = '0;
  logic [1:0] en_s = '0;
  logic [1:0] pol_s = '0;
  logic [1:0] oe_s = '0;
  logic [1:0][1:0] ps_s = '0;
  logic [1:0][1:0] ns_s = '0;
  logic [31:0] rdat;
  logic [1:0] resp;
  int err_total = 0;
  int n_tests = 0;
  assign tclk = tpu ? tpre : tsrc;

  dcc_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .axi_req(req), .axi_rsp(rsp),
    .raw_compare(raw), .analog_ctrl(actl), .timer_src_clk(tsrc), .timer_prescale_clk(tpre),
    .timer_prescale_used(tpu), .timer_gate(gate), .pin_direction(dir), .pin_out(pout),
    .pin_out_en(poe), .pin_override(povr), .pwm_shutdown_src(pwm), .compare_irq_flag(flg));
  dcc_far_model far_u (.ref_clk(ref_clk), .analog_ctrl(actl), .pos_lvl(pos), .neg_lvl(neg),
    .raw_compare(raw), .timer_src_clk(tsrc), .timer_prescale_clk(tpre));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic tmo();
    err_total++;
    final_report();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Handshake flags are sampled mid-cycle, where they equal what the next edge sees
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    b = 1'b0;
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (int k = 0; k < 50 && !b; k++) begin
      @(negedge ref_clk);
      aw = rsp.awready;
      w = rsp.wready;
      b = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge ref_clk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
      if (b) req.bready <= 1'b0;
    end
    @(posedge ref_clk);
    if (!b) tmo();
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar, r;
    r = 1'b0;
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (int k = 0; k < 50 && !r; k++) begin
      @(negedge ref_clk);
      ar = rsp.arready;
      r = rsp.rvalid;
      rdat = rsp.rdata;
      resp = rsp.rresp;
      @(posedge ref_clk);
      if (ar) req.arvalid <= 1'b0;
      if (r) req.rready <= 1'b0;
    end
    @(posedge ref_clk);
    if (!r) tmo();
  endtask

  task automatic cfg(input int i, input logic [7:0] a, input logic [7:0] b);
    en_s[i] = a[7];
    oe_s[i] = a[5];
    pol_s[i] = a[4];
    ps_s[i] = b[5:4];
    ns_s[i] = b[1:0];
    wr(dcc_pkg::OFF_CTRL_B[i], {24'h0, b});
    wr(dcc_pkg::OFF_CTRL_A[i], {24'h0, a});
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic wclk(input logic v);
    for (int m = 0; m < 200; m++) begin
      @(posedge ref_clk);
      if (tclk === v) return;
    end
    tmo();
  endtask

  function automatic logic f_res(input int i);
    logic [7:0] vp;
    vp = (ps_s[i] == 2'h3) ? 8'h00 : pos[ps_s[i]];
    return (en_s[i] & (vp > neg[ns_s[i]])) ^ pol_s[i];
  endfunction

  initial begin
    int i;
    logic [7:0] a, b;
    logic [1:0] e;
    logic o;
    void'($urandom(41660));
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    wr(dcc_pkg::OFF_MIRROR, 32'h000000FF);
    chk({30'h0, resp}, {30'h0, dcc_pkg::RESP_OKAY});
    for (int k = 0; k < 7; k++) begin
      rd(8'(k * 4));
      chk(rdat, (k == 0 || k == 2) ? 32'h00000004 : 32'h00000000);
      chk({30'h0, resp}, {30'h0, k == 6 ? dcc_pkg::RESP_SLVERR : dcc_pkg::RESP_OKAY});
    end
    $display("test reset done");
    for (int n = 0; n < 40; n++) begin
      i = $urandom % 2;
      a = 8'($urandom) & 8'hB6;
      b = 8'($urandom) & 8'h33;
      pos <= $urandom;
      neg <= $urandom;
      dir <= 2'($urandom);
      cfg(i, a, b);
      e = {f_res(1), f_res(0)};
      rd(dcc_pkg::OFF_CTRL_A[i]);
      chk(rdat, {24'h0, a[7], e[i], a[5:0]});
      rd(dcc_pkg::OFF_MIRROR);
      chk(rdat, {30'h0, e});
      chk({26'h0, gate, pout, pwm}, {26'h0, e, e, e});
      chk({28'h0, poe, povr}, {28'h0, oe_s & ~dir & en_s, oe_s});
      chk({24'h0, actl[i]}, {24'h0, a[7], a[7], a[2], a[1], b[5:4], b[1:0]});
    end
    $display("test random done");
    cfg(1, 8'h00, 8'h00);
    pos[0] <= 8'h10;
    neg[0] <= 8'h20;
    for (int k = 0; k < 4; k++) begin
      cfg(0, 8'h84, {k[1], k[0], 6'h00});
      wr(dcc_pkg::OFF_FLAGS, 32'h3);
      pos[0] <= 8'h30;
      repeat (4) @(posedge ref_clk);
      chk({30'h0, flg}, {31'h0, k[1]});
      wr(dcc_pkg::OFF_FLAGS, 32'h3);
      chk({30'h0, flg}, 32'h0);
      pos[0] <= 8'h10;
      repeat (4) @(posedge ref_clk);
      rd(dcc_pkg::OFF_FLAGS);
      chk(rdat, {31'h0, k[0]});
    end
    cfg(0, 8'h04, 8'h80);
    wr(dcc_pkg::OFF_FLAGS, 32'h3);
    cfg(0, 8'h14, 8'h80);
    chk({30'h0, flg}, 32'h1);
    $display("test flags done");
    cfg(0, 8'h85, 8'h00);
    for (int k = 0; k < 2; k++) begin
      tpu <= k[0];
      wclk(1'b0);
      wclk(1'b1);
      o = gate[0];
      pos[0] <= o ? 8'h10 : 8'h30;
      repeat (k ? 20 : 3) @(posedge ref_clk);
      chk({29'h0, gate[0], pout[0], pwm[0]}, {29'h0, {3{o}}});
      wclk(1'b0);
      repeat (3) @(posedge ref_clk);
      chk({29'h0, gate[0], pout[0], pwm[0]}, {29'h0, {3{~o}}});
    end
    $display("test sync done");
    final_report();
  end
endmodule // dual_comparator_control_tb_top
`default_nettype wire
